// [tamt_pkg.sv]
`default_nettype none
package tamt_pkg;
    // Clock and one-second time base
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SEC_NS = 1_000_000_000;
    localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    // Times in seconds
    localparam int unsigned SAVE_PERIOD_S = 1;
    localparam int unsigned CONFIRM_WINDOW_S = 2;
    localparam int unsigned NOTICE_S = 2;
    localparam int unsigned DELAY_MAX_S = 3600;
    // Temperature limits in tenths of a degree
    localparam logic signed [11:0] TEMP_MIN = -12'sd99;
    localparam logic signed [11:0] TEMP_MAX = 12'sd999;
    // Start-flow threshold in tenths of a percent of full scale
    localparam logic [10:0] START_MAX = 11'h3E8;
    // Reset values
    localparam logic TEMP_EN_RST = 1'b0;
    localparam logic LATCH_RST = 1'b0;
    localparam logic TOT_EN_RST = 1'b0;

    typedef enum logic [1:0]
    {
        TAMT_IDLE = 2'b00,
        TAMT_CONFIRM = 2'b01,
        TAMT_NOTICE = 2'b10
    } tamt_rst_state_t;

    typedef struct packed
    {
        logic enable;
        logic latch;
        logic signed [11:0] low_limit;
        logic signed [11:0] high_limit;
        logic [11:0] delay_s;
    } tamt_temp_cfg_t;

    typedef struct packed
    {
        logic low;
        logic high;
        logic range;
    } tamt_temp_evt_t;
endpackage
`default_nettype wire

// [tamt_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Temperature alarm enable setting, disabled after reset.
// RULE2: Low temperature limit in tenths of a degree, -9.9 to 99.9 C.
// RULE3: High temperature limit in tenths of a degree, same range.
// RULE4: Configuring party keeps high limit strictly above low limit.
// RULE5: Alarm condition when reading at or above high, or at or below low.
// RULE6: Alarm indicated only after condition holds for 0 to 3600 seconds.
// RULE7: Low temperature output energised while below the low limit; the code also energises it at the limit (reading <= low).
// RULE8: Latch setting off by default; outputs follow status or stay on.
// RULE9: Totalizer enable, disabled by default; accumulate only when enabled.
// RULE10: Totalizer integrates flow, saves each second, reloads at power-up.
// RULE11: No accumulation while flow is below the start threshold.
// RULE12: Start threshold in 0.1 percent steps, 0.0 to 100.0 percent.
// RULE13: Event true when total equals event volume; zero disables event.
// RULE14: Nonzero stop volume halts accumulation once reached; zero never stops.
// RULE15: Reset request opens 2 s window; confirm clears total; 2 s notice.
// RULE16: Latched output clears only on latch off, alarm off or reassignment.
module tamt_top
    import tamt_pkg::*;
#(
    parameter int unsigned TOT_W = 32,
    parameter int unsigned SEC_CNT = SEC_CYCLES
)
(
    input wire logic CLK_IN, // 125 MHz clock
    input wire logic SYS_RST_IN, // Async reset, active high
    input wire logic TEMP_EN_IN, // Temperature alarm enable
    input wire logic TEMP_LATCH_IN, // Latch mode for alarm outputs
    input wire logic signed [11:0] TEMP_LOW_IN, // Low limit, 0.1 C
    input wire logic signed [11:0] TEMP_HIGH_IN, // High limit, 0.1 C
    input wire logic [11:0] TEMP_DELAY_IN, // Action delay, seconds
    input wire logic signed [11:0] TEMP_READ_IN, // Temperature reading, 0.1 C
    input wire logic OUT_REASSIGN_IN, // Pulse: output assignment changed
    input wire logic TOT_EN_IN, // Main totalizer enable
    input wire logic [10:0] FLOW_PCT_IN, // Flow, 0.1 percent full scale
    input wire logic [10:0] START_PCT_IN, // Start threshold, 0.1 percent
    input wire logic [15:0] FLOW_INC_IN, // Volume per second at current flow
    input wire logic [TOT_W-1:0] EVENT_VOL_IN, // Event volume, 0 disables
    input wire logic [TOT_W-1:0] STOP_VOL_IN, // Stop volume, 0 disables
    input wire logic [TOT_W-1:0] NV_LOAD_IN, // Last saved total
    input wire logic NV_VALID_IN, // Pulse: saved total available
    input wire logic RESET_REQ_IN, // Pulse: reset key pressed
    input wire logic CONFIRM_IN, // Pulse: confirm key pressed
    output logic TEMP_ALARM_OUT, // Indicated alarm flag
    output logic TEMP_LOW_OUT, // Low temperature event output
    output logic TEMP_HIGH_OUT, // High temperature event output
    output logic TEMP_RANGE_OUT, // Any temperature event output
    output logic [TOT_W-1:0] TOTAL_OUT, // Main volume total
    output logic TOT_EVENT_OUT, // Totalizer event
    output logic TOT_STOPPED_OUT, // Stop volume reached
    output logic NV_SAVE_OUT, // Pulse: write total to memory
    output logic [TOT_W-1:0] NV_DATA_OUT, // Total to save
    output logic CONFIRM_WIN_OUT, // Confirmation window open
    output logic NOTICE_OUT // Reset notice shown
);
    localparam int unsigned SEC_W = $clog2(SEC_CNT + 1);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CNT - 1);
    localparam logic [1:0] CONF_S = 2'(CONFIRM_WINDOW_S);
    localparam logic [1:0] NOTE_S = 2'(NOTICE_S);
    localparam logic [11:0] DELAY_CAP = 12'(DELAY_MAX_S);

    tamt_temp_cfg_t cfg;
    tamt_temp_evt_t live;
    tamt_temp_evt_t ind_r;
    tamt_temp_evt_t ind_nxt;
    tamt_temp_evt_t out_r;
    tamt_temp_evt_t out_nxt;
    tamt_rst_state_t st_r;
    tamt_rst_state_t st_nxt;

    logic [SEC_W-1:0] sec_cnt_r;
    logic sec_tick;
    logic [11:0] low_s_r;
    logic [11:0] high_s_r;
    logic [11:0] delay_eff;
    logic low_cond;
    logic high_cond;
    logic [TOT_W-1:0] total_r;
    logic [TOT_W-1:0] total_nxt;
    logic [TOT_W:0] sum;
    logic [TOT_W-1:0] sum_sat;
    logic stop_hit;
    logic accum;
    logic [10:0] start_eff;
    logic save_r;
    logic [TOT_W-1:0] save_data_r;
    logic [1:0] st_sec_r;
    logic latch_clr;

    // Clamp a limit into the settable range
    function automatic logic signed [11:0] clamp_t(input logic signed [11:0] v);
        clamp_t = (v < TEMP_MIN) ? TEMP_MIN : ((v > TEMP_MAX) ? TEMP_MAX : v);
    endfunction

    //--------------------------------------------------------------
    // One-second time base
    //--------------------------------------------------------------
    assign sec_tick = (sec_cnt_r == SEC_LAST);

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            sec_cnt_r <= '0;
        else
            sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 1'b1;
    end

    //--------------------------------------------------------------
    // Temperature alarm
    //--------------------------------------------------------------
    assign cfg.enable = TEMP_EN_IN; // RULE1
    assign cfg.latch = TEMP_LATCH_IN;
    assign cfg.low_limit = clamp_t(TEMP_LOW_IN); // RULE2
    assign cfg.high_limit = clamp_t(TEMP_HIGH_IN); // RULE3
    assign cfg.delay_s = TEMP_DELAY_IN;
    assign delay_eff = (cfg.delay_s > DELAY_CAP) ? DELAY_CAP : cfg.delay_s; // RULE6

    assign low_cond = cfg.enable && (TEMP_READ_IN <= cfg.low_limit); // RULE5
    assign high_cond = cfg.enable && (TEMP_READ_IN >= cfg.high_limit); // RULE5

    // Seconds each condition has held; saturates one past the cap
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            low_s_r <= '0;
            high_s_r <= '0;
        end
        else
        begin
            low_s_r <= !low_cond ? '0
                : ((sec_tick && low_s_r <= DELAY_CAP) ? low_s_r + 1'b1 : low_s_r);
            high_s_r <= !high_cond ? '0
                : ((sec_tick && high_s_r <= DELAY_CAP) ? high_s_r + 1'b1 : high_s_r);
        end
    end

    // Count must pass the delay by one tick, since the first second may be partial
    assign live.low = low_cond && (delay_eff == 12'h000 || low_s_r > delay_eff); // RULE6
    assign live.high = high_cond && (delay_eff == 12'h000 || high_s_r > delay_eff); // RULE6
    assign live.range = live.low || live.high;
    assign ind_nxt = live;

    assign latch_clr = !cfg.latch || !cfg.enable || OUT_REASSIGN_IN; // RULE16
    assign out_nxt = latch_clr ? live : (out_r | live); // RULE8

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            ind_r <= '0;
            out_r <= '0;
        end
        else
        begin
            ind_r <= ind_nxt;
            out_r <= out_nxt;
        end
    end

    assign TEMP_ALARM_OUT = ind_r.range;
    assign TEMP_LOW_OUT = out_r.low; // RULE7
    assign TEMP_HIGH_OUT = out_r.high;
    assign TEMP_RANGE_OUT = out_r.range;

    //--------------------------------------------------------------
    // Main totalizer
    //--------------------------------------------------------------
    assign stop_hit = (STOP_VOL_IN != '0) && (total_r >= STOP_VOL_IN); // RULE14
    assign start_eff = (START_PCT_IN > START_MAX) ? START_MAX : START_PCT_IN; // RULE12
    assign accum = TOT_EN_IN && sec_tick && !stop_hit // RULE9
        && (FLOW_PCT_IN >= start_eff); // RULE11
    assign sum = {1'b0, total_r} + {{(TOT_W - 15){1'b0}}, FLOW_INC_IN}; // RULE10
    assign sum_sat = sum[TOT_W] ? '1 : sum[TOT_W-1:0];

    always_comb
    begin
        total_nxt = total_r;
        if (NV_VALID_IN)
            total_nxt = NV_LOAD_IN; // RULE10
        else if (st_r == TAMT_CONFIRM && CONFIRM_IN)
            total_nxt = '0; // RULE15
        else if (accum)
        begin
            total_nxt = sum_sat;
            if (STOP_VOL_IN != '0 && sum_sat > STOP_VOL_IN)
                total_nxt = STOP_VOL_IN; // RULE14
        end
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            total_r <= '0;
            save_r <= 1'b0;
            save_data_r <= '0;
        end
        else
        begin
            total_r <= total_nxt;
            save_r <= sec_tick; // RULE10
            if (sec_tick)
                save_data_r <= total_r;
        end
    end

    assign TOTAL_OUT = total_r;
    assign TOT_EVENT_OUT = (EVENT_VOL_IN != '0) && (total_r == EVENT_VOL_IN); // RULE13
    assign TOT_STOPPED_OUT = stop_hit;
    assign NV_SAVE_OUT = save_r;
    assign NV_DATA_OUT = save_data_r;

    //--------------------------------------------------------------
    // Keypad reset with confirmation
    //--------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            TAMT_IDLE:
                if (RESET_REQ_IN)
                    st_nxt = TAMT_CONFIRM;
            TAMT_CONFIRM:
                if (CONFIRM_IN)
                    st_nxt = TAMT_NOTICE; // RULE15
                else if (sec_tick && st_sec_r == CONF_S - 2'd1)
                    st_nxt = TAMT_IDLE;
            TAMT_NOTICE:
                if (sec_tick && st_sec_r == NOTE_S - 2'd1)
                    st_nxt = TAMT_IDLE;
            default:
                st_nxt = TAMT_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            st_r <= TAMT_IDLE;
            st_sec_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_nxt != st_r)
                st_sec_r <= '0;
            else if (sec_tick)
                st_sec_r <= st_sec_r + 2'd1;
        end
    end

    assign CONFIRM_WIN_OUT = (st_r == TAMT_CONFIRM);
    assign NOTICE_OUT = (st_r == TAMT_NOTICE);

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    a_low_needs_cond: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE5
        (ind_r.low |-> $past(TEMP_READ_IN) <= $past(cfg.low_limit)))
        else $error("low alarm without low condition");
    a_disabled_quiet: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE1
        (!cfg.enable ##1 !cfg.enable) |-> !TEMP_ALARM_OUT && !TEMP_RANGE_OUT)
        else $error("alarm while disabled");
    a_zero_delay: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE6
        (high_cond && delay_eff == 12'h000) |=> TEMP_HIGH_OUT)
        else $error("zero delay alarm late");
    a_delay_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE6
        (live.high |-> high_s_r >= delay_eff))
        else $error("alarm before delay");
    a_follow_mode: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE8
        (!cfg.latch |=> TEMP_LOW_OUT == $past(live.low)))
        else $error("non-latching output not following");
    a_latch_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE16
        (TEMP_LOW_OUT && !latch_clr) |=> TEMP_LOW_OUT)
        else $error("latched output dropped");
    a_no_accum_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE9
        (!TOT_EN_IN && !NV_VALID_IN && !(CONFIRM_IN && CONFIRM_WIN_OUT))
        |=> TOTAL_OUT == $past(TOTAL_OUT))
        else $error("total moved while disabled");
    a_start_flow: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE11
        (FLOW_PCT_IN < start_eff && !NV_VALID_IN && !(CONFIRM_IN && CONFIRM_WIN_OUT))
        |=> TOTAL_OUT == $past(TOTAL_OUT))
        else $error("total moved below start flow");
    a_stop_cap: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE14
        (stop_hit && !NV_VALID_IN && !(CONFIRM_IN && CONFIRM_WIN_OUT))
        |=> TOTAL_OUT == $past(TOTAL_OUT))
        else $error("total moved after stop");
    a_event_eq: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE13
        (TOT_EVENT_OUT |-> TOTAL_OUT == EVENT_VOL_IN && EVENT_VOL_IN != '0))
        else $error("event without match");
    a_confirm_clear: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE15
        (CONFIRM_WIN_OUT && CONFIRM_IN && !NV_VALID_IN) |=> TOTAL_OUT == '0 && NOTICE_OUT)
        else $error("confirm did not clear total");
    a_save_tick: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE10
        sec_tick |=> NV_SAVE_OUT && NV_DATA_OUT == $past(TOTAL_OUT))
        else $error("save missed");
    a_delay_early: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE6
        (!cfg.latch && high_cond && delay_eff != 12'h000 && high_s_r <= delay_eff) |=> !TEMP_HIGH_OUT)
        else $error("alarm before delay elapsed");
    a_req_opens: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RULE15
        (!CONFIRM_WIN_OUT && !NOTICE_OUT && RESET_REQ_IN) |=> CONFIRM_WIN_OUT)
        else $error("reset request did not open window");
endmodule
`default_nettype wire

// [tamt_nv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tamt_nv_model
(
    input wire logic clk_in, // Meter clock
    input wire logic rst_in, // Power-up reset, active high
    input wire logic save_in, // Write strobe from the block
    input wire logic [31:0] data_in, // Total to store
    output logic [31:0] load_out, // Stored total
    output logic valid_out // Stored total presented
);
    logic [31:0] mem_r = 32'h0000_0000;

    always @(posedge clk_in)
    begin
        if (save_in)
        begin
            mem_r <= data_in;
        end
    end

    // Replay the stored total once after every power-up, then scramble the bus
    initial
    begin
        valid_out = 1'b0;
        load_out = 32'h0000_0000;
        forever
        begin
            @(negedge rst_in);
            repeat (3) @(negedge clk_in);
            load_out = mem_r;
            valid_out = 1'b1;
            @(negedge clk_in);
            valid_out = 1'b0;
            load_out = ~mem_r;
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench
    import tamt_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic t_en, t_latch, reassign, tot_en, nv_valid, req, conf, conf_ok;
    logic signed [11:0] t_low, t_high, t_rd;
    logic [11:0] t_dly;
    logic [10:0] flow, start, s_flow, s_start, lim;
    logic [15:0] inc, s_inc;
    logic [31:0] ev_vol, stop_vol, s_stop, nv_load, total, nv_data, m;
    logic [31:0] saved = 32'h0000_0000;
    logic t_alarm, t_lo, t_hi, t_rng, tot_ev, tot_stop, nv_save, win, notice;
    logic s_en, s_ld, s_clr;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 79277;
    int r;
    int rd[7] = '{-99, -1, 0, 1, 499, 500, 999};

    always #4 clk = ~clk;

    tamt_top #(.SEC_CNT(10)) u_dut
    (
        .CLK_IN(clk), .SYS_RST_IN(rst), .TEMP_EN_IN(t_en), .TEMP_LATCH_IN(t_latch),
        .TEMP_LOW_IN(t_low), .TEMP_HIGH_IN(t_high), .TEMP_DELAY_IN(t_dly),
        .TEMP_READ_IN(t_rd), .OUT_REASSIGN_IN(reassign), .TOT_EN_IN(tot_en),
        .FLOW_PCT_IN(flow), .START_PCT_IN(start), .FLOW_INC_IN(inc),
        .EVENT_VOL_IN(ev_vol), .STOP_VOL_IN(stop_vol), .NV_LOAD_IN(nv_load),
        .NV_VALID_IN(nv_valid), .RESET_REQ_IN(req), .CONFIRM_IN(conf),
        .TEMP_ALARM_OUT(t_alarm), .TEMP_LOW_OUT(t_lo), .TEMP_HIGH_OUT(t_hi),
        .TEMP_RANGE_OUT(t_rng), .TOTAL_OUT(total), .TOT_EVENT_OUT(tot_ev),
        .TOT_STOPPED_OUT(tot_stop), .NV_SAVE_OUT(nv_save), .NV_DATA_OUT(nv_data),
        .CONFIRM_WIN_OUT(win), .NOTICE_OUT(notice)
    );

    tamt_nv_model u_nv
    (
        .clk_in(clk), .rst_in(rst), .save_in(nv_save), .data_in(nv_data),
        .load_out(nv_load), .valid_out(nv_valid)
    );

    //--------------------------------------------
    // Totalizer model
    //--------------------------------------------
    // Inputs as the design takes them at each rising edge
    always @(posedge clk)
    begin
        {s_en, s_flow, s_start, s_inc, s_stop} = {tot_en, flow, start, inc, stop_vol};
        {s_ld, s_clr} = {nv_valid, conf & conf_ok};
    end

    always @(negedge clk)
    begin
        #1;
        if (rst)
            m = 32'h0000_0000;
        else
        begin
            lim = (s_start > START_MAX) ? START_MAX : s_start;
            if (nv_save)
            begin
                `CHK("nv_data", m, nv_data)
                saved = m;
            end
            if (s_ld)
                m = saved;
            else if (s_clr)
                m = 32'h0000_0000;
            else if (nv_save && s_en && s_flow >= lim
                && !(s_stop != 0 && m >= s_stop))
                m = (s_stop != 0 && m + s_inc > s_stop) ? s_stop : m + s_inc;
            `CHK("total", m, total)
            `CHK("event", ev_vol != 0 && m == ev_vol, tot_ev)
            `CHK("stopped", stop_vol != 0 && m >= stop_vol, tot_stop)
        end
    end

    //--------------------------------------------
    // Tasks
    //--------------------------------------------
    task automatic tc(input int v, input logic [2:0] e);
        t_rd = 12'(v);
        repeat (2) @(negedge clk);
        `CHK("temp_low_high_alarm", e, {t_lo, t_hi, t_alarm})
        `CHK("temp_range", e[2] | e[1], t_rng)
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #32000;
        mismatches++;
        give_verdict();
    end

    //--------------------------------------------
    // Scenarios
    //--------------------------------------------
    initial
    begin
        {t_en, t_latch, reassign, tot_en, req, conf, conf_ok} = 7'h00;
        t_low = 12'sh000;
        t_high = 12'sh1F4;
        t_dly = 12'h000;
        t_rd = 12'sh000;
        {flow, start, inc} = {11'h000, 11'h12C, 16'h0000};
        {ev_vol, stop_vol} = {2{32'h0000_0000}};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        tc(999, 3'h0);
        t_en = 1'b1;
        for (int i = 0; i < 11; i++)
        begin
            r = (i < 7) ? rd[i] : ((($random(seed) & 32'h0000_FFFF) % 1099) - 99);
            tc(r, {r <= 0, r >= 500, r <= 0 || r >= 500});
        end
        tc(250, 3'h0);
        t_dly = 12'h002;
        tc(600, 3'h0);
        repeat (17) @(negedge clk);
        `CHK("early_alarm", 1'b0, t_alarm)
        repeat (16) @(negedge clk);
        `CHK("delayed_alarm", 1'b1, t_alarm)
        t_dly = 12'h000;
        tc(250, 3'h0);
        t_latch = 1'b1;
        tc(600, 3'h3);
        tc(250, 3'h2);
        pulse(reassign);
        tc(250, 3'h0);
        tc(-50, 3'h5);
        t_latch = 1'b0;
        tc(250, 3'h0);
        for (int i = 0; i < 16; i++)
        begin
            tot_en = i > 2;
            start = (i == 9) ? 11'h5DC : 11'h12C;
            flow = (i == 9) ? 11'h3E8 : 11'(($random(seed) & 32'h0000_FFFF) % 1001);
            inc = 16'($random(seed) & 32'h0000_003F);
            repeat (10) @(negedge clk);
        end
        tot_en = 1'b0;
        {flow, inc} = {11'h3E8, 16'h0010};
        repeat (2) @(negedge clk);
        ev_vol = m + 32'h0000_0020;
        stop_vol = m + 32'h0000_0025;
        tot_en = 1'b1;
        repeat (60) @(negedge clk);
        `CHK("stop_total", stop_vol, total)
        stop_vol = 32'h0000_0000;
        pulse(req);
        `CHK("window", 1'b1, win)
        repeat (25) @(negedge clk);
        `CHK("window_end", 1'b0, win)
        pulse(conf);
        pulse(req);
        @(negedge clk);
        conf_ok = 1'b1;
        pulse(conf);
        conf_ok = 1'b0;
        `CHK("notice", 1'b1, notice)
        repeat (25) @(negedge clk);
        `CHK("notice_end", 1'b0, notice)
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        give_verdict();
    end
endmodule
`default_nettype wire
